// *** design/dir_pkg.sv ***
package dir_pkg;

   // ----------------------------------------------------------------
   // Register indices; the byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [7:0]  REV_HIGH_IDX  = 8'h1A;
   localparam logic [7:0]  REV_LOW_IDX   = 8'h1B;
   localparam logic [7:0]  MEM_FIRST_IDX = 8'h1C;
   localparam logic [7:0]  MEM_SECOND_IDX = 8'h1D;
   localparam int          ADDR_W        = 12;

   // ----------------------------------------------------------------
   // Revision identifier field positions
   // ----------------------------------------------------------------
   localparam int          MAJ_FAM_LSB   = 12;
   localparam int          MIN_FAM_LSB   = 8;
   localparam int          MAJ_MASK_LSB  = 4;
   localparam int          MIN_MASK_LSB  = 0;
   localparam int          FIELD_W       = 4;

   // Arbitrary neutral identity values
   localparam logic [3:0]  MAJ_FAM_VAL   = 4'h1;
   localparam logic [3:0]  MIN_FAM_VAL   = 4'h2;
   localparam logic [3:0]  MAJ_MASK_VAL  = 4'h3;
   localparam logic [3:0]  MIN_MASK_VAL  = 4'h4;

   // ----------------------------------------------------------------
   // Memory size constants
   // ----------------------------------------------------------------
   localparam logic [7:0]  MEM_FIRST_VAL  = 8'h11;
   localparam logic [7:0]  MEM_SECOND_VAL = 8'h80;

   // ----------------------------------------------------------------
   // Bus responses
   // ----------------------------------------------------------------
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   typedef enum logic [1:0] {DIR_W_IDLE, DIR_W_RESP} dir_wstate_e;

endpackage : dir_pkg

// *** design/dir_id_rom.sv ***
`timescale 1ns/1ps
module dir_id_rom
   import dir_pkg::*;
(
   // Lookup
   input  wire logic [ADDR_W-1:0] addr,
   output logic      [7:0]        data,
   output logic                   hit
);
   logic [15:0] rev_id;

   always_comb begin
      rev_id = {MAJ_FAM_VAL, MIN_FAM_VAL, MAJ_MASK_VAL, MIN_MASK_VAL};
      hit    = 1'b1;
      case (addr)
         {2'h0, REV_HIGH_IDX, 2'h0}:   data = rev_id[15:8];
         {2'h0, REV_LOW_IDX, 2'h0}:    data = rev_id[7:0];
         {2'h0, MEM_FIRST_IDX, 2'h0}:  data = MEM_FIRST_VAL;
         {2'h0, MEM_SECOND_IDX, 2'h0}: data = MEM_SECOND_VAL;
         default: begin
            data = 8'h00;
            hit  = 1'b0;
         end
      endcase
   end
endmodule : dir_id_rom

// *** design/dir_regs.sv ***
`timescale 1ns/1ps
module dir_regs
   import dir_pkg::*;
(
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // Write address
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   // Write data
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // Write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // Read address
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   // Read data
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);
   // ----------------------------------------------------------------
   // Write channel
   // ----------------------------------------------------------------
   logic aw_seen_q, aw_seen_d;
   logic w_seen_q,  w_seen_d;
   logic bvalid_q,  bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic [ADDR_W-1:0] awaddr_q, awaddr_d;
   logic wr_hit;
   logic [ADDR_W-1:0] wr_dec_addr;

   // Decoded from port or held address, so no loop through the comb block
   assign wr_dec_addr = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : awaddr_q;

   // Write address only decoded; no storage, so data is dropped
   dir_id_rom u_wr_dec (
      .addr (wr_dec_addr),
      .data (),
      .hit  (wr_hit)
   );

   assign s_axi_awready = !aw_seen_q && !bvalid_q;
   assign s_axi_wready  = !w_seen_q && !bvalid_q;

   always_comb begin
      aw_seen_d = aw_seen_q;
      w_seen_d  = w_seen_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      awaddr_d  = awaddr_q;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_seen_d = 1'b1;
         awaddr_d  = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_seen_d = 1'b1;
      end
      if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      if (aw_seen_d && w_seen_d && !bvalid_q) begin
         bvalid_d  = 1'b1;
         aw_seen_d = 1'b0;
         w_seen_d  = 1'b0;
         bresp_d   = wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_seen_q <= 1'b0;
         w_seen_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
         awaddr_q  <= '0;
      end else begin
         aw_seen_q <= aw_seen_d;
         w_seen_q  <= w_seen_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         awaddr_q  <= awaddr_d;
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;

   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   logic        rvalid_q, rvalid_d;
   logic [31:0] rdata_q,  rdata_d;
   logic [1:0]  rresp_q,  rresp_d;
   logic [7:0]  rd_byte;
   logic        rd_hit;

   dir_id_rom u_rd_dec (
      .addr (s_axi_araddr),
      .data (rd_byte),
      .hit  (rd_hit)
   );

   assign s_axi_arready = !rvalid_q;

   always_comb begin
      rvalid_d = rvalid_q;
      rdata_d  = rdata_q;
      rresp_d  = rresp_q;
      if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_d = 1'b1;
         rdata_d  = {24'h000000, rd_byte};
         rresp_d  = rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h00000000;
         rresp_q  <= RESP_OKAY;
      end else begin
         rvalid_q <= rvalid_d;
         rdata_q  <= rdata_d;
         rresp_q  <= rresp_d;
      end
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata  = rdata_q;
   assign s_axi_rresp  = rresp_q;
endmodule : dir_regs

// *** verification/dir_regs_properties.sv ***
`timescale 1ns/1ps
module dir_regs_properties
   import dir_pkg::*;
(
   // Clock and reset
   input wire logic              aclk,
   input wire logic              aresetn,
   // Write side
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic              s_axi_awvalid,
   input wire logic              s_axi_awready,
   input wire logic              s_axi_wvalid,
   input wire logic              s_axi_wready,
   input wire logic [1:0]        s_axi_bresp,
   input wire logic              s_axi_bvalid,
   // Read side
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic              s_axi_arvalid,
   input wire logic              s_axi_arready,
   input wire logic [31:0]       s_axi_rdata,
   input wire logic [1:0]        s_axi_rresp,
   input wire logic              s_axi_rvalid
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ------------------------------------------------------------
   // Read address taken
   // ------------------------------------------------------------
   sequence rd_at(a);
      s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
   endsequence
   rev_high_a: assert property (rd_at(12'h068) |=>
      s_axi_rdata == {24'h0, MAJ_FAM_VAL, MIN_FAM_VAL})
      else $error("rev high wrong");
   rev_low_a: assert property (rd_at(12'h06C) |=>
      s_axi_rdata == {24'h0, MAJ_MASK_VAL, MIN_MASK_VAL})
      else $error("rev low wrong");
   mem_first_a: assert property (rd_at(12'h070) |=> s_axi_rdata == 32'h11)
      else $error("mem first wrong");
   mem_second_a: assert property (rd_at(12'h074) |=> s_axi_rdata == 32'h80)
      else $error("mem second wrong");
   rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("no read answer");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while busy");
   rd_unmapped_a: assert property (rd_at(12'h078) |=> s_axi_rresp == RESP_SLVERR)
      else $error("unmapped read ok");
   wr_okay_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready && s_axi_awaddr inside {12'h068, 12'h06C, 12'h070, 12'h074}
      |=> s_axi_bvalid && s_axi_bresp == RESP_OKAY)
      else $error("mapped write refused");
endmodule : dir_regs_properties

bind dir_regs dir_regs_properties i_dir_regs_properties (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid));

// *** verification/test_dir_regs.sv ***
`timescale 1ns/1ps
module test_dir_regs
   import dir_pkg::*;
;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [1:0]  bresp, rresp, r;
   int          error_cnt, n_tests;
   dir_regs i_dir_regs (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   // ------------------------------------------------------------
   // Reporting
   // ------------------------------------------------------------
   task results;
      if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : results
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         error_cnt++;
      end
   endtask : chk
   // Handshakes judged at negedge: ready is settled there and holds to the edge
   task xfer(input bit wr, input logic [11:0] a);
      int n;
      bit h1, h2, h3, h4, h5;
      // One idle edge first: no signal assigned twice in one step
      @(posedge aclk);
      n = 0;
      {r, d} = 'x;
      if (wr) {awaddr, awvalid, wvalid, bready} <= {a, 3'b111};
      else {araddr, arvalid, rready} <= {a, 2'b11};
      while ((awvalid || wvalid || bready || arvalid || rready || n == 0) && n < 50) begin
         @(negedge aclk);
         {h1, h2, h3} = {awvalid && awready, wvalid && wready, bvalid && bready};
         {h4, h5} = {arvalid && arready, rvalid && rready};
         if (h3) r = bresp;
         if (h5) {r, d} = {rresp, rdata};
         @(posedge aclk);
         n++;
         if (h1) awvalid <= 1'b0;
         if (h2) wvalid <= 1'b0;
         if (h3) bready <= 1'b0;
         if (h4) arvalid <= 1'b0;
         if (h5) rready <= 1'b0;
      end
      if (n >= 50) begin
         error_cnt++;
         results;
      end
   endtask : xfer
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task s_rw(input bit wr);
      logic [31:0] exp_tbl[4];
      exp_tbl = '{{24'h0, MAJ_FAM_VAL, MIN_FAM_VAL}, {24'h0, MAJ_MASK_VAL, MIN_MASK_VAL},
                  32'h11, 32'h80};
      for (int i = 0; i < 4; i++) begin
         if (wr) xfer(1'b1, 12'h068 + 12'(4 * i));
         if (wr) chk(32'(r), 32'(RESP_OKAY));
         xfer(1'b0, 12'h068 + 12'(4 * i));
         chk(d, exp_tbl[i]);
         chk(32'(r), 32'(RESP_OKAY));
      end
   endtask : s_rw
   task s_unmapped;
      xfer(1'b0, 12'h078);
      chk(32'(r), 32'(RESP_SLVERR));
      xfer(1'b1, 12'h078);
      chk(32'(r), 32'(RESP_SLVERR));
   endtask : s_unmapped
   task s_reset;
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(negedge aclk);
      chk({29'h0, awready, wready, arready}, 32'h7);
      chk({30'h0, bvalid, rvalid}, 32'h0);
   endtask : s_reset
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr} <= '0;
      wdata <= 32'hFFFFFFFF;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      s_rw(1'b0);
      s_rw(1'b1);
      s_unmapped;
      s_reset;
      s_rw(1'b0);
      results;
   end
endmodule : test_dir_regs
